// File: include/mnco_pkg.sv
// Package of constants for the multichannel oscillator core
package mnco_pkg;
  localparam int A_W       = 32;  // Accumulator precision
  localparam int F_W       = 32;  // Frequency modulation resolution
  localparam int P_W       = 32;  // Phase modulation precision
  localparam int ANG_W     = 17;  // Angular precision into the sine table
  localparam int M_W       = 18;  // Magnitude precision
  localparam int CHANNELS  = 4;   // Channel count, 1 to 8
  localparam int CH_MAX    = 8;
  localparam int CH_W      = 3;
  localparam int BANDS     = 16;  // Hop register depth
  localparam int BAND_W    = 4;
  localparam int ADDR_W    = 3;   // Width of the hop write address port
  localparam int MOD_PIPE  = 1;   // Pipeline depth on modulation paths
  localparam int DITHER_LVL = 3;  // Dither variance level, 0 disables
  localparam int LFSR_W    = 16;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
  localparam logic [A_W-1:0]    INC_RST   = 32'h0000_0000;
  localparam int LUT_W     = 8;   // Quarter wave table address bits
endpackage

// File: hdl/mnco_sincos.sv
// Registered sine and cosine lookup from a phase word
`timescale 1ns/100ps
module mnco_sincos (
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            clken_i,
  input  wire logic [mnco_pkg::ANG_W-1:0]      phase_i,
  output logic signed [mnco_pkg::M_W-1:0]      sin_o,
  output logic signed [mnco_pkg::M_W-1:0]      cos_o
);
  localparam int N = 1 << mnco_pkg::LUT_W;
  localparam real PI = 3.14159265358979;
  localparam int AMP = (1 << (mnco_pkg::M_W - 1)) - 1;

  // Quarter wave value at table index
  function automatic logic [mnco_pkg::M_W-1:0] qwave(input logic [mnco_pkg::LUT_W-1:0] idx);
    real ang;
    ang = (PI / 2.0) * (real'(idx) + 0.5) / real'(N);
    return mnco_pkg::M_W'($rtoi($sin(ang) * AMP));
  endfunction

  // Full wave from quadrant and index, with sign
  function automatic logic signed [mnco_pkg::M_W-1:0] wave(input logic [mnco_pkg::ANG_W-1:0] ph);
    logic [mnco_pkg::LUT_W-1:0] idx;
    logic [mnco_pkg::M_W-1:0]   mag;
    idx = ph[mnco_pkg::ANG_W-3 -: mnco_pkg::LUT_W];
    if (ph[mnco_pkg::ANG_W-2]) begin
      idx = ~idx;
    end
    mag = qwave(idx);
    return ph[mnco_pkg::ANG_W-1] ? -$signed(mag) : $signed(mag);
  endfunction

  logic [mnco_pkg::ANG_W-1:0] quarter;
  assign quarter = mnco_pkg::ANG_W'(1) << (mnco_pkg::ANG_W - 2);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sin_o <= '0;
      cos_o <= '0;
    end else if (clken_i) begin
      sin_o <= wave(phase_i);
      cos_o <= wave(phase_i + quarter);
    end
  end
endmodule

// File: hdl/mnco_core.sv
// Multichannel numerically controlled oscillator with frequency hopping
//
// Summary of operation
// - Write address selects a phase-increment register
// - Write strobe stores value into addressed register, only while hop enable high
// - Hop select chooses register driving the accumulator
// - Frequency modulation input offsets the increment
// - Phase modulation input offsets accumulated phase
// - Cosine output beside sine, magnitude width
// - State advances only while clock enable high
// - Active-low reset clears state asynchronously; the dither LFSR loads LFSR_SEED
// - Four channels share one oscillator, interleaved
// - Valid, start and end mark channel rounds
// - Modulation resolution configurable; modulation pipeline fixed at one stage, MOD_PIPE unused
// - Selectable dither level adds pseudo-random phase
// - Hop select change applies next cycle
// - Valid rises with first channel 0 sample
// - Channel count allowed from one to eight
`timescale 1ns/100ps
module mnco_core (
  input  wire logic                                clk_i,
  input  wire logic                                rstn_i,
  input  wire logic                                clken_i,
  input  wire logic                                hop_en_i,
  input  wire logic [mnco_pkg::ADDR_W-1:0]         address_i,
  input  wire logic                                write_sig_i,
  input  wire logic [mnco_pkg::BAND_W-1:0]         freq_sel_i,
  input  wire logic [mnco_pkg::A_W-1:0]            phi_inc_i,
  input  wire logic [mnco_pkg::F_W-1:0]            freq_mod_i,
  input  wire logic [mnco_pkg::P_W-1:0]            phase_mod_i,
  output logic signed [mnco_pkg::M_W-1:0]          fsin_o,
  output logic signed [mnco_pkg::M_W-1:0]          fcos_o,
  output logic                                     out_valid_o,
  output logic                                     sop_o,
  output logic                                     eop_o
);
  localparam int DW  = mnco_pkg::DITHER_LVL;

  typedef enum logic [1:0] {
    MNCO_IDLE  = 2'b00,
    MNCO_FILL  = 2'b01,
    MNCO_RUN   = 2'b11
  } mnco_state_t;

  // Channel index increment with wrap at the configured count
  function automatic logic [mnco_pkg::CH_W-1:0] next_ch(input logic [mnco_pkg::CH_W-1:0] c);
    return (c == mnco_pkg::CH_W'(mnco_pkg::CHANNELS - 1)) ? '0 : c + 1'b1;
  endfunction

  logic [mnco_pkg::A_W-1:0]   inc_bank [mnco_pkg::BANDS];
  logic [mnco_pkg::BAND_W-1:0] sel_q;
  logic [mnco_pkg::A_W-1:0]   acc [mnco_pkg::CH_MAX];
  logic [mnco_pkg::CH_W-1:0]  in_ch;
  logic [mnco_pkg::A_W-1:0]   inc_q;
  logic [mnco_pkg::F_W-1:0]   fmod_q;
  logic [mnco_pkg::P_W-1:0]   pmod_q;
  logic [mnco_pkg::CH_W-1:0]  p_ch;
  logic                       p_vld;
  logic [mnco_pkg::A_W-1:0]   phase_q;
  logic                       ph_vld;
  logic [mnco_pkg::LFSR_W-1:0] lfsr;
  logic [mnco_pkg::ANG_W-1:0] angle;
  logic [mnco_pkg::A_W-1:0]   sel_inc;
  logic [mnco_pkg::A_W-1:0]   next_acc;
  logic [mnco_pkg::CH_W-1:0]  out_ch;
  mnco_state_t                state;

  // Hop register writes; address port is 3 bits over 16 bands
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < mnco_pkg::BANDS; i++) begin
        inc_bank[i] <= mnco_pkg::INC_RST;
      end
    end else if (clken_i && hop_en_i && write_sig_i) begin
      inc_bank[mnco_pkg::BAND_W'(address_i)] <= phi_inc_i;
    end
  end

  // Hop select registered, takes effect next cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= '0;
    end else if (clken_i) begin
      sel_q <= freq_sel_i;
    end
  end

  assign sel_inc = hop_en_i ? inc_bank[sel_q] : phi_inc_i;

  // Input slot counter, channel 0 first after reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_ch <= '0;
    end else if (clken_i) begin
      in_ch <= next_ch(in_ch);
    end
  end

  // Modulation input pipeline stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inc_q  <= '0;
      fmod_q <= '0;
      pmod_q <= '0;
      p_ch   <= '0;
      p_vld  <= 1'b0;
    end else if (clken_i) begin
      inc_q  <= sel_inc;
      fmod_q <= freq_mod_i;
      pmod_q <= phase_mod_i;
      p_ch   <= in_ch;
      p_vld  <= 1'b1;
    end
  end

  assign next_acc = acc[p_ch] + inc_q + mnco_pkg::A_W'(fmod_q);

  // Per-channel accumulators
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < mnco_pkg::CH_MAX; i++) begin
        acc[i] <= '0;
      end
    end else if (clken_i && p_vld) begin
      acc[p_ch] <= next_acc;
    end
  end

  // Phase offset stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= '0;
      ph_vld  <= 1'b0;
    end else if (clken_i) begin
      phase_q <= next_acc + mnco_pkg::A_W'(pmod_q);
      ph_vld  <= p_vld;
    end
  end

  // Dither sequence generator
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lfsr <= mnco_pkg::LFSR_SEED;
    end else if (clken_i) begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ mnco_pkg::LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // Truncated phase plus the low DW bits of the dither LFSR
  always_comb begin
    angle = phase_q[mnco_pkg::A_W-1 -: mnco_pkg::ANG_W];
    if (DW > 0) begin
      angle = angle + mnco_pkg::ANG_W'(lfsr[DW-1:0]);
    end
  end

  mnco_sincos u_sincos (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .clken_i (clken_i),
    .phase_i (angle),
    .sin_o   (fsin_o),
    .cos_o   (fcos_o)
  );

  // Channel tag of the phase word now entering the lookup
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_ch <= '0;
    end else if (clken_i) begin
      out_ch <= p_ch;
    end
  end

  // Output framing state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= MNCO_IDLE;
    end else if (clken_i) begin
      case (state)
        MNCO_IDLE: state <= p_vld ? MNCO_FILL : MNCO_IDLE;
        MNCO_FILL: state <= MNCO_RUN;
        MNCO_RUN:  state <= MNCO_RUN;
        default:   state <= MNCO_IDLE;
      endcase
    end
  end

  // Stream markers aligned with the lookup output
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_valid_o <= 1'b0;
      sop_o       <= 1'b0;
      eop_o       <= 1'b0;
    end else if (clken_i) begin
      out_valid_o <= ph_vld && (state != MNCO_IDLE);
      sop_o       <= ph_vld && (state != MNCO_IDLE) && (out_ch == '0);
      eop_o       <= ph_vld && (state != MNCO_IDLE)
                     && (out_ch == mnco_pkg::CH_W'(mnco_pkg::CHANNELS - 1));
    end
  end
endmodule

// File: bench/mnco_core_assertions.sv
// Concurrent checks on the oscillator core ports
`timescale 1ns/100ps
module mnco_core_chk (
  input wire logic                            clk_i,
  input wire logic                            rstn_i,
  input wire logic                            clken_i,
  input wire logic signed [mnco_pkg::M_W-1:0] fsin_o,
  input wire logic signed [mnco_pkg::M_W-1:0] fcos_o,
  input wire logic                            out_valid_o,
  input wire logic                            sop_o,
  input wire logic                            eop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_sop_valid: assert property (sop_o |-> out_valid_o && !eop_o)
    else $error("start marker without valid");
  chk_eop_valid: assert property (eop_o |-> out_valid_o)
    else $error("end marker without valid");
  chk_eop_after_sop: assert property (sop_o && clken_i ##1 clken_i ##1 clken_i |=> eop_o)
    else $error("end marker not three samples after start");
  chk_sop_after_eop: assert property (eop_o && clken_i |=> sop_o)
    else $error("round not followed by channel zero");
  chk_first_sop: assert property ($rose(out_valid_o) |-> sop_o)
    else $error("first valid sample not channel zero");
  chk_valid_run: assert property (out_valid_o && clken_i |=> out_valid_o)
    else $error("gap in sample stream");
  chk_hold_clken: assert property (!clken_i |=> $stable(fsin_o) && $stable(fcos_o)
    && $stable(out_valid_o))
    else $error("outputs moved while disabled");
  chk_reset_clear: assert property (disable iff (1'b0) !rstn_i |-> fsin_o == '0
    && fcos_o == '0 && !out_valid_o)
    else $error("outputs not cleared in reset");
  chk_start_bound: assert property ($rose(rstn_i) |-> ##[1:20] out_valid_o)
    else $error("no valid sample after reset");
  cover property (sop_o);
  cover property (eop_o && clken_i);
  cover property (!clken_i && out_valid_o);
endmodule

// File: bench/mnco_src_model.sv
// Upstream source presenting per-channel inputs in ascending slot order
`timescale 1ns/100ps
module mnco_src_model (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        clken_i,
  input  wire logic [mnco_pkg::A_W-1:0]    inc_tbl_i [4],
  input  wire logic [mnco_pkg::F_W-1:0]    fmod_tbl_i [4],
  input  wire logic [mnco_pkg::P_W-1:0]    pmod_tbl_i [4],
  output logic      [mnco_pkg::A_W-1:0]    phi_inc_o,
  output logic      [mnco_pkg::F_W-1:0]    freq_mod_o,
  output logic      [mnco_pkg::P_W-1:0]    phase_mod_o
);
  logic [1:0] slot;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot <= 2'h0;
    end else if (clken_i) begin
      slot <= slot + 2'h1;
    end
  end
  always_comb begin
    phi_inc_o   = inc_tbl_i[slot];
    freq_mod_o  = fmod_tbl_i[slot];
    phase_mod_o = pmod_tbl_i[slot];
  end
endmodule

// File: bench/tb_mnco_core.sv
// Self-checking bench for the oscillator core
`timescale 1ns/100ps
module tb_mnco_core;
  logic clk = 1'b0, rstn, clken, hop_en, wr, vld, sop, eop;
  logic [mnco_pkg::ADDR_W-1:0] addr;
  logic [mnco_pkg::BAND_W-1:0] fsel;
  logic [31:0] inc [4], fm [4], pm [4], phi, fmv, pmv;
  logic signed [mnco_pkg::M_W-1:0] fsin, fcos;
  int err_count = 0, tests_run = 0;
  always #25 clk = ~clk;
  mnco_core uut (.clk_i(clk), .rstn_i(rstn), .clken_i(clken), .hop_en_i(hop_en),
    .address_i(addr), .write_sig_i(wr), .freq_sel_i(fsel), .phi_inc_i(phi),
    .freq_mod_i(fmv), .phase_mod_i(pmv), .fsin_o(fsin), .fcos_o(fcos),
    .out_valid_o(vld), .sop_o(sop), .eop_o(eop));
  mnco_src_model src (.clk_i(clk), .rstn_i(rstn), .clken_i(clken), .inc_tbl_i(inc),
    .fmod_tbl_i(fm), .pmod_tbl_i(pm), .phi_inc_o(phi), .freq_mod_o(fmv), .phase_mod_o(pmv));
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  function automatic int cls(logic signed [mnco_pkg::M_W-1:0] v);
    if (^v === 1'bx) return 9;
    if (v > 60000) return 1;
    if (v < -60000) return -1;
    return (v < 4096 && v > -4096) ? 0 : 9;
  endfunction
  task automatic grab(output int s[4], output int c[4]);
    for (int i = 0; i < 40 && sop !== 1'b1; i++) @(negedge clk);
    chk(sop === 1'b1 && vld === 1'b1, "no valid start sample");
    for (int k = 0; k < 4; k++) begin
      s[k] = cls(fsin);
      c[k] = cls(fcos);
      if (k == 3) chk(eop === 1'b1, "no end marker");
      @(negedge clk);
    end
  endtask
  task automatic step_chk(input int ch, input int mode);
    int s0[4], c0[4], s1[4], c1[4];
    grab(s0, c0);
    grab(s0, c0);
    grab(s1, c1);
    chk(s0[ch] * s0[ch] + c0[ch] * c0[ch] == 1, "off quadrant");
    case (mode)
      0: chk(s1[ch] === s0[ch] && c1[ch] === c0[ch], "phase drift");
      1: chk(s1[ch] === c0[ch] && c1[ch] === -s0[ch], "no quarter step");
      default: chk(s1[ch] === -s0[ch] && c1[ch] === -c0[ch], "no half step");
    endcase
  endtask
  task automatic do_reset;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
  endtask
  task automatic t_phase;
    int s[4], c[4];
    grab(s, c);
    grab(s, c);
    chk(s[0] === 0 && s[1] === 1 && s[2] === 0 && s[3] === -1, "sine levels");
    chk(c[0] === 1 && c[1] === 0 && c[2] === -1 && c[3] === 0, "cosine levels");
  endtask
  task automatic t_mod;
    fm[0] = 32'h8000_0000;
    inc[2] = 32'h4000_0000;
    do_reset();
    step_chk(0, 2);
    step_chk(2, 1);
    step_chk(3, 0);
    fm[0] = 32'h0000_0000;
  endtask
  task automatic t_hop;
    foreach (inc[i]) inc[i] = 32'h4000_0000;
    hop_en = 1'b1;
    addr = 3'h3;
    wr = 1'b1;
    @(negedge clk);
    hop_en = 1'b0;
    addr = 3'h5;
    @(negedge clk);
    wr = 1'b0;
    hop_en = 1'b1;
    foreach (inc[i]) inc[i] = 32'h0000_0000;
    fsel = 4'h3;
    step_chk(1, 1);
    fsel = 4'h5;
    step_chk(1, 0);
    hop_en = 1'b0;
    fsel = 4'h0;
  endtask
  task automatic t_hold;
    logic signed [mnco_pkg::M_W-1:0] s;
    logic v;
    s = fsin;
    v = vld;
    clken = 1'b0;
    repeat (6) begin
      @(negedge clk);
      chk(fsin === s && vld === v, "output moved while disabled");
    end
    clken = 1'b1;
  endtask
  task automatic t_reset;
    @(negedge clk);
    rstn = 1'b0;
    #1;
    chk(fsin === '0 && fcos === '0 && vld === 1'b0 && sop === 1'b0, "not cleared");
    @(negedge clk);
    rstn = 1'b1;
    t_phase();
  endtask
  initial begin
    rstn = 1'b1;
    clken = 1'b1;
    hop_en = 1'b0;
    wr = 1'b0;
    addr = 3'h0;
    fsel = 4'h0;
    foreach (inc[i]) begin
      inc[i] = 32'h0000_0000;
      fm[i] = 32'h0000_0000;
      pm[i] = {i[1:0], 30'h0000_0000};
    end
    #1;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_phase();
    t_mod();
    t_hop();
    t_hold();
    t_reset();
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule
bind mnco_core mnco_core_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .clken_i(clken_i),
  .fsin_o(fsin_o), .fcos_o(fcos_o), .out_valid_o(out_valid_o), .sop_o(sop_o), .eop_o(eop_o));
